// File: logic/pll_divider_regs.vh
// register indices, field positions, reset values and widths of the pll divider bank
`ifndef PLL_DIVIDER_REGS_VH
`define PLL_DIVIDER_REGS_VH

// register indices; byte address is four times the index
`define PLL_IDX_REF_LOW 10'h011
`define PLL_IDX_REF_HIGH 10'h012
`define PLL_IDX_SWALLOW 10'h013
`define PLL_IDX_MAIN_LOW 10'h014
`define PLL_IDX_MAIN_HIGH 10'h015
`define PLL_IDX_CONTROL 10'h016
`define PLL_IDX_STATUS 10'h018

// reset values
`define PLL_RST_REF_LOW 8'h01
`define PLL_RST_REF_HIGH 6'h00
`define PLL_RST_SWALLOW 6'h00
`define PLL_RST_MAIN_LOW 8'h03
`define PLL_RST_MAIN_HIGH 5'h00
`define PLL_RST_CONTROL 8'h06

// field widths
`define PLL_REF_HIGH_W 6
`define PLL_SWALLOW_W 6
`define PLL_MAIN_HIGH_W 5
`define PLL_REF_W 14
`define PLL_MAIN_W 13

// control register bit positions
`define PLL_CTL_CP_MID 7
`define PLL_CTL_REF_RST 6
`define PLL_CTL_FB_RST 5
`define PLL_CTL_ALL_RST 4
`define PLL_CTL_BYPASS 3
`define PLL_CTL_PRESC_HI 2
`define PLL_CTL_PRESC_LO 0

// prescaler selections that are fixed divide
`define PLL_PRESC_FD1 3'h0
`define PLL_PRESC_FD2 3'h1
`define PLL_PRESC_FD3 3'h7

// status register bit positions
`define PLL_ST_REF_RUN 0
`define PLL_ST_FB_RUN 1
`define PLL_ST_MODULUS 2
`define PLL_ST_FIXED 3
`define PLL_ST_BYPASS_BAD 4

`endif

// File: logic/edge_sync2.v
// two-flop synchroniser for pin inputs
module edge_sync2 #(
   parameter WIDTH = 1
) (
   input wire clock_i,
   input wire reset_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // first stage feeds only the second
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // edge_sync2

// File: logic/divide_counter.v
// loadable divide-by-n counter with hold, counts input strobes
module divide_counter #(
   parameter WIDTH = 14
) (
   input wire clock_i,
   input wire reset_i,
   input wire hold_i,
   input wire strobe_i,
   input wire [WIDTH-1:0] divide_i,
   output wire wrap_o,
   output wire [WIDTH-1:0] count_o
);

   reg [WIDTH-1:0] count_q;
   wire last;

   // zero and one both divide by one
   assign last = (divide_i <= {{(WIDTH-1){1'b0}}, 1'b1}) ||
                 (count_q >= divide_i - {{(WIDTH-1){1'b0}}, 1'b1});
   assign wrap_o = strobe_i & ~hold_i & last;
   assign count_o = count_q;

   // counter held at zero while hold is high
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         count_q <= {WIDTH{1'b0}};
      end else if (hold_i) begin
         count_q <= {WIDTH{1'b0}};
      end else if (strobe_i) begin
         if (last) begin
            count_q <= {WIDTH{1'b0}};
         end else begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // divide_counter

// File: logic/pll_divider_config.v
// pll reference and feedback divider configuration bank with apb slave
`include "pll_divider_regs.vh"

module pll_divider_config #(
   parameter ADDR_W = 12
) (
   input wire clock_i,
   input wire reset_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [ADDR_W-1:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // pins from the analog side
   input wire ref_pin_i,
   input wire prescaler_pin_i,
   // divider outputs
   output wire ref_div_o,
   output wire fb_div_o,
   output wire modulus_o,
   output wire charge_pump_mid_o,
   output wire ref_hold_o,
   output wire fb_hold_o
);

   // register storage
   reg [7:0] ref_low_q;
   reg [`PLL_REF_HIGH_W-1:0] ref_high_q;
   reg [`PLL_SWALLOW_W-1:0] swallow_q;
   reg [7:0] main_low_q;
   reg [`PLL_MAIN_HIGH_W-1:0] main_high_q;
   reg [7:0] control_q;
   reg [31:0] prdata_q;
   reg ref_hold_q;
   reg fb_hold_q;

   // divider state
   reg [`PLL_SWALLOW_W-1:0] swallow_cnt_q;
   reg [`PLL_SWALLOW_W-1:0] swallow_cnt_d;
   reg modulus_q;
   reg modulus_d;
   reg ref_div_q;
   reg fb_div_q;
   reg ref_run_q;
   reg fb_run_q;
   reg ref_prev_q;
   reg presc_prev_q;

   // bus decode
   wire [9:0] index;
   wire setup;
   wire access;
   wire write_en;
   wire hit;
   reg [31:0] read_word;
   reg read_hit;

   // divider wiring
   wire [1:0] pin_sync;
   wire ref_sync;
   wire presc_sync;
   wire ref_edge;
   wire presc_edge;
   wire [`PLL_REF_W-1:0] ref_divide;
   wire [`PLL_MAIN_W-1:0] main_value;
   wire [`PLL_MAIN_W-1:0] main_divide;
   wire [2:0] presc_sel;
   wire fixed_divide_mode;
   wire bypass;
   wire ref_hold;
   wire fb_hold;
   wire ref_wrap;
   wire main_wrap;
   wire [`PLL_REF_W-1:0] ref_count;
   wire [`PLL_MAIN_W-1:0] main_count;
   wire [7:0] status_word;
   wire bypass_misuse;
   wire ref_run_d;
   wire fb_run_d;

   // apb phases; registers answer with no wait state
   assign index = paddr_i[11:2];
   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i;
   assign write_en = access & pwrite_i & pstrb_i[0];
   assign hit = read_hit;
   assign pready_o = 1'b1;
   assign pslverr_o = access & ~hit;
   assign prdata_o = prdata_q;

   // fields assembled from the stored bytes
   assign ref_divide = {ref_high_q, ref_low_q};
   assign main_value = {main_high_q, main_low_q};
   assign presc_sel = control_q[`PLL_CTL_PRESC_HI:`PLL_CTL_PRESC_LO];
   assign fixed_divide_mode = (presc_sel == `PLL_PRESC_FD1) ||
                              (presc_sel == `PLL_PRESC_FD2) ||
                              (presc_sel == `PLL_PRESC_FD3);
   assign bypass = control_q[`PLL_CTL_BYPASS];
   assign main_divide = bypass ? {{(`PLL_MAIN_W-1){1'b0}}, 1'b1} : main_value;

   // counter holds, registered copies of the control hold bits
   assign ref_hold = ref_hold_q;
   assign fb_hold = fb_hold_q;

   // bypass while the prescaler is dual modulus is a software fault
   assign bypass_misuse = bypass & ~fixed_divide_mode;

   // status seen by software
   assign status_word = {3'h0,
                         bypass_misuse,
                         fixed_divide_mode,
                         modulus_q,
                         fb_run_q,
                         ref_run_q};

   // read mux, narrow fields zero-extended
   always @* begin
      read_word = 32'h00000000;
      read_hit = 1'b1;
      if (index == `PLL_IDX_REF_LOW) begin
         read_word = {24'h000000, ref_low_q};
      end else if (index == `PLL_IDX_REF_HIGH) begin
         read_word = {26'h0, ref_high_q};
      end else if (index == `PLL_IDX_SWALLOW) begin
         read_word = {26'h0, swallow_q};
      end else if (index == `PLL_IDX_MAIN_LOW) begin
         read_word = {24'h000000, main_low_q};
      end else if (index == `PLL_IDX_MAIN_HIGH) begin
         read_word = {27'h0, main_high_q};
      end else if (index == `PLL_IDX_CONTROL) begin
         read_word = {24'h000000, control_q};
      end else if (index == `PLL_IDX_STATUS) begin
         read_word = {24'h000000, status_word};
      end else begin
         read_hit = 1'b0;
      end
   end

   // read data captured in the setup phase, from a flop
   // so that it stands steady through the access cycle
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         prdata_q <= 32'h00000000;
      end else if (setup & ~pwrite_i) begin
         prdata_q <= read_word;
      end
   end

   // register writes on the access edge
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ref_low_q <= `PLL_RST_REF_LOW;
         ref_high_q <= `PLL_RST_REF_HIGH;
         swallow_q <= `PLL_RST_SWALLOW;
         main_low_q <= `PLL_RST_MAIN_LOW;
         main_high_q <= `PLL_RST_MAIN_HIGH;
         control_q <= `PLL_RST_CONTROL;
         ref_hold_q <= 1'b0;
         fb_hold_q <= 1'b0;
      end else if (write_en) begin
         if (index == `PLL_IDX_REF_LOW) begin
            ref_low_q <= pwdata_i[7:0];
         end else if (index == `PLL_IDX_REF_HIGH) begin
            ref_high_q <= pwdata_i[`PLL_REF_HIGH_W-1:0];
         end else if (index == `PLL_IDX_SWALLOW) begin
            swallow_q <= pwdata_i[`PLL_SWALLOW_W-1:0];
         end else if (index == `PLL_IDX_MAIN_LOW) begin
            main_low_q <= pwdata_i[7:0];
         end else if (index == `PLL_IDX_MAIN_HIGH) begin
            main_high_q <= pwdata_i[`PLL_MAIN_HIGH_W-1:0];
         end else if (index == `PLL_IDX_CONTROL) begin
            control_q <= pwdata_i[7:0];
            ref_hold_q <= pwdata_i[`PLL_CTL_REF_RST] | pwdata_i[`PLL_CTL_ALL_RST];
            fb_hold_q <= pwdata_i[`PLL_CTL_FB_RST] | pwdata_i[`PLL_CTL_ALL_RST];
         end
      end
   end

   // pins pass two flops before use
   edge_sync2 #(
      .WIDTH(2)
   ) u_pin_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i({prescaler_pin_i, ref_pin_i}),
      .sync_o(pin_sync)
   );

   // bit 0 reference pin, bit 1 prescaler pin
   assign ref_sync = pin_sync[0];
   assign presc_sync = pin_sync[1];

   // rising edge detect on the synchronised pins
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ref_prev_q <= 1'b0;
         presc_prev_q <= 1'b0;
      end else begin
         ref_prev_q <= ref_sync;
         presc_prev_q <= presc_sync;
      end
   end

   // one-cycle strobe per rising pin edge
   assign ref_edge = ref_sync & ~ref_prev_q;
   assign presc_edge = presc_sync & ~presc_prev_q;

   // reference divider counter
   divide_counter #(
      .WIDTH(`PLL_REF_W)
   ) u_ref_counter (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .hold_i(ref_hold),
      .strobe_i(ref_edge),
      .divide_i(ref_divide),
      .wrap_o(ref_wrap),
      .count_o(ref_count)
   );

   // main counter of the feedback divider
   divide_counter #(
      .WIDTH(`PLL_MAIN_W)
   ) u_main_counter (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .hold_i(fb_hold),
      .strobe_i(presc_edge),
      .divide_i(main_divide),
      .wrap_o(main_wrap),
      .count_o(main_count)
   );

   // swallow count and modulus select for dual modulus prescaling
   always @* begin
      swallow_cnt_d = swallow_cnt_q;
      modulus_d = 1'b0;
      if (fb_hold) begin
         swallow_cnt_d = {`PLL_SWALLOW_W{1'b0}};
      end else if (presc_edge) begin
         if (main_wrap) begin
            swallow_cnt_d = {`PLL_SWALLOW_W{1'b0}};
         end else if (swallow_cnt_q != swallow_q) begin
            swallow_cnt_d = swallow_cnt_q + {{(`PLL_SWALLOW_W-1){1'b0}}, 1'b1};
         end
      end
      // no swallowing in fixed divide or bypass
      if (~fb_hold && ~fixed_divide_mode && ~bypass) begin
         modulus_d = (swallow_cnt_d < swallow_q);
      end
   end

   // a counter runs when released and has moved off zero or is wrapping
   assign ref_run_d = ~ref_hold & ((ref_count != {`PLL_REF_W{1'b0}}) | ref_wrap);
   assign fb_run_d = ~fb_hold & ((main_count != {`PLL_MAIN_W{1'b0}}) | main_wrap);

   // divider state and output pulses
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         swallow_cnt_q <= {`PLL_SWALLOW_W{1'b0}};
         modulus_q <= 1'b0;
         ref_div_q <= 1'b0;
         fb_div_q <= 1'b0;
         ref_run_q <= 1'b0;
         fb_run_q <= 1'b0;
      end else begin
         swallow_cnt_q <= swallow_cnt_d;
         modulus_q <= modulus_d;
         ref_div_q <= ref_wrap;
         fb_div_q <= main_wrap;
         ref_run_q <= ref_run_d;
         fb_run_q <= fb_run_d;
      end
   end

   // outputs toward the analog pll
   assign ref_div_o = ref_div_q;
   assign fb_div_o = fb_div_q;
   assign modulus_o = modulus_q;
   assign charge_pump_mid_o = control_q[`PLL_CTL_CP_MID];
   assign ref_hold_o = ref_hold;
   assign fb_hold_o = fb_hold;

endmodule // pll_divider_config

// File: verification/pll_divider_config_assertions.sv
// concurrent checks for the pll divider configuration bank
module pll_divider_config_assertions #(
   parameter ADDR_W = 12
) (
   input logic clock_i,
   input logic reset_i,
   input logic psel_i,
   input logic penable_i,
   input logic pwrite_i,
   input logic [ADDR_W-1:0] paddr_i,
   input logic [31:0] pwdata_i,
   input logic [3:0] pstrb_i,
   input logic pslverr_o,
   input logic prescaler_pin_i,
   input logic ref_div_o,
   input logic fb_div_o,
   input logic modulus_o,
   input logic charge_pump_mid_o,
   input logic ref_hold_o,
   input logic fb_hold_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   logic [7:0] ctl_q;
   wire [9:0] idx = paddr_i[11:2];
   wire acc = psel_i & penable_i;
   wire mapped = (idx >= 10'h011 && idx <= 10'h016) || idx == 10'h018;
   wire ctl_wr = acc & pwrite_i & pstrb_i[0] & (idx == 10'h016);
   wire fixed = ctl_q[2:0] == 3'h0 || ctl_q[2:0] == 3'h1 || ctl_q[2:0] == 3'h7;
   wire bypass_on = ctl_q[3] & fixed & ~(ctl_q[4] | ctl_q[5]);
   // shadow of the control register
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) ctl_q <= 8'h06;
      else if (ctl_wr) ctl_q <= pwdata_i[7:0];
   end
   sequence ctl_write;
      ctl_wr;
   endsequence
   sequence presc_edge;
      $rose(prescaler_pin_i) ##0 bypass_on;
   endsequence
   a_cp_mid_write: assert property (ctl_write |=> charge_pump_mid_o == $past(pwdata_i[7]))
      else $error("pump park bit not applied");
   a_ref_hold_write: assert property (ctl_write |=>
      ref_hold_o == ($past(pwdata_i[6]) | $past(pwdata_i[4])))
      else $error("reference hold wrong");
   a_fb_hold_write: assert property (ctl_write |=>
      fb_hold_o == ($past(pwdata_i[5]) | $past(pwdata_i[4])))
      else $error("feedback hold wrong");
   a_ctl_outs_stable: assert property (!ctl_wr |=>
      $stable({charge_pump_mid_o, ref_hold_o, fb_hold_o}))
      else $error("control outputs moved without write");
   a_ref_held_quiet: assert property (ref_hold_o [*3] |-> !ref_div_o)
      else $error("reference pulse while held");
   a_fb_held_quiet: assert property (fb_hold_o [*3] |-> !fb_div_o && !modulus_o)
      else $error("feedback active while held");
   a_bypass_every: assert property (presc_edge |-> ##[2:5] fb_div_o)
      else $error("bypass missed a prescaler edge");
   a_fixed_no_mod: assert property (fixed && $past(fixed) |-> !modulus_o)
      else $error("modulus raised in fixed divide");
   a_err_map: assert property (acc |-> pslverr_o == !mapped)
      else $error("error response wrong for address");
endmodule // pll_divider_config_assertions

bind pll_divider_config pll_divider_config_assertions #(.ADDR_W(ADDR_W)) chk (
   .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .pslverr_o(pslverr_o), .prescaler_pin_i(prescaler_pin_i), .ref_div_o(ref_div_o),
   .fb_div_o(fb_div_o), .modulus_o(modulus_o), .charge_pump_mid_o(charge_pump_mid_o),
   .ref_hold_o(ref_hold_o), .fb_hold_o(fb_hold_o));

// File: verification/pll_divider_config_bench.sv
// self-checking bench for the pll divider configuration bank
module pll_divider_config_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, rd, d;
   logic [3:0] pstrb_i = 4'h0;
   logic ref_pin_i = 0, prescaler_pin_i = 0;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, ref_div_o, fb_div_o, modulus_o, charge_pump_mid_o;
   wire ref_hold_o, fb_hold_o;
   int num_errors = 0, comparisons = 0, ref_n, fb_n, mod_n, a, r;
   logic mod_prev = 0;
   integer seed = 41;
   logic [7:0] rst_v[6] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06};
   logic [7:0] msk[6] = '{8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'h1F, 8'hFF};
   logic [7:0] ctl_v[6] = '{8'h08, 8'h00, 8'h40, 8'h20, 8'h06, 8'h10};
   always #2 clock_i = ~clock_i;
   pll_divider_config dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .ref_pin_i(ref_pin_i), .prescaler_pin_i(prescaler_pin_i), .ref_div_o(ref_div_o),
      .fb_div_o(fb_div_o), .modulus_o(modulus_o), .charge_pump_mid_o(charge_pump_mid_o),
      .ref_hold_o(ref_hold_o), .fb_hold_o(fb_hold_o));
   // divider pulse and modulus rise counters
   always @(posedge clock_i) begin
      if (ref_div_o === 1'b1) ref_n++;
      if (fb_div_o === 1'b1) fb_n++;
      if (modulus_o === 1'b1 && mod_prev !== 1'b1) mod_n++;
      mod_prev <= modulus_o;
   end
   function automatic int pulses(input int n, div, held);
      return held ? 0 : (div <= 1 ? n : n / div);
   endfunction
   // swallow phase opens on release and again after every main wrap
   function automatic int rises(input int n, div, dual);
      return dual ? 1 + n / div : 0;
   endfunction
   task automatic check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
         input logic [3:0] s);
      int n;
      @(posedge clock_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= ad;
      pwdata_i <= wd;
      pstrb_i <= s;
      @(posedge clock_i);
      penable_i <= 1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   // park all counters, apply control, run 30 pin edges
   task automatic run_pins(input logic [7:0] ctl, input int er, ef, em);
      apb(1, 12'h058, 32'h10, 4'h1);
      apb(1, 12'h058, {24'h0, ctl}, 4'h1);
      ref_n = 0;
      fb_n = 0;
      mod_n = 0;
      repeat (30) begin
         @(posedge clock_i);
         ref_pin_i <= 1;
         prescaler_pin_i <= 1;
         repeat (2) @(posedge clock_i);
         ref_pin_i <= 0;
         prescaler_pin_i <= 0;
         @(posedge clock_i);
      end
      repeat (8) @(posedge clock_i);
      check(ref_n, er);
      check(fb_n, ef);
      check(mod_n, em);
   endtask
   initial begin
      repeat (6) @(posedge clock_i);
      reset_i <= 0;
      foreach (rst_v[i]) begin
         apb(0, 12'(12'h044 + 4 * i), 32'h0, 4'h0);
         check(rd, {24'h0, rst_v[i]});
         check(err, 1'b0);
      end
      $display("reset values done");
      repeat (24) begin
         a = {$random(seed)} % 6;
         d = $random(seed);
         apb(1, 12'(12'h044 + 4 * a), d, 4'h1);
         apb(0, 12'(12'h044 + 4 * a), 32'h0, 4'h0);
         check(rd, {24'h0, d[7:0] & msk[a]});
      end
      apb(1, 12'h050, 32'h5A, 4'h1);
      apb(1, 12'h050, 32'hA5, 4'h0);
      apb(0, 12'h050, 32'h0, 4'h0);
      check(rd, 32'h5A);
      apb(0, 12'h064, 32'h0, 4'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      $display("register access done");
      for (int b = 3; b < 8; b++) begin
         apb(1, 12'h058, 32'h1 << b, 4'h1);
         @(posedge clock_i);
         check({charge_pump_mid_o, ref_hold_o, fb_hold_o},
            {b == 7, b == 6 || b == 4, b == 5 || b == 4});
      end
      $display("control bits done");
      apb(1, 12'h050, 32'h05, 4'h1);
      apb(1, 12'h054, 32'h00, 4'h1);
      apb(1, 12'h048, 32'h00, 4'h1);
      apb(1, 12'h04C, 32'h02, 4'h1);
      foreach (ctl_v[i]) begin
         r = ({$random(seed)} % 4) + 2;
         apb(1, 12'h044, r, 4'h1);
         run_pins(ctl_v[i], pulses(30, r, ctl_v[i][6] | ctl_v[i][4]),
            pulses(30, ctl_v[i][3] ? 1 : 5, ctl_v[i][5] | ctl_v[i][4]),
            rises(30, 5, ctl_v[i] == 8'h06));
      end
      $display("divider runs done");
      apb(1, 12'h060, 32'hFF, 4'h1);
      check(err, 1'b0);
      apb(0, 12'h060, 32'h0, 4'h0);
      check(rd, 32'h08);
      $display("status done");
      print_verdict();
   end
endmodule // pll_divider_config_bench
